/* src/rie_pkg.sv */
// rie_pkg: constants, state codes and carrier structs for the return
// instruction executor.
// assumes the core supplies 16-bit instruction words and a 21-bit pc.
`default_nettype none

package rie_pkg;

  localparam int PC_W = 21;
  localparam int DATA_W = 8;
  localparam int INSTR_W = 16;

  // return from interrupt: 0000 0000 0001 000s
  localparam logic [15:0] RFI_MASK = 16'hfffe;
  localparam logic [15:0] RFI_CODE = 16'h0010;
  // return from subroutine: 0000 0000 0001 001s
  localparam logic [15:0] RFS_MASK = 16'hfffe;
  localparam logic [15:0] RFS_CODE = 16'h0012;
  // return with literal: 0000 1100 kkkk kkkk
  localparam logic [15:0] RWL_MASK = 16'hff00;
  localparam logic [15:0] RWL_CODE = 16'h0c00;

  localparam int SEL_BIT = 0;
  localparam int LIT_LSB = 0;

  // four phases of one instruction cycle
  localparam logic [1:0] PH_Q1 = 2'h0;
  localparam logic [1:0] PH_Q3 = 2'h2;
  localparam logic [1:0] PH_Q4 = 2'h3;

  typedef enum logic [1:0] {
    RIE_KIND_NONE = 2'b00,
    RIE_KIND_RFI = 2'b01,
    RIE_KIND_RWL = 2'b10,
    RIE_KIND_RFS = 2'b11
  } rie_kind_t;

  typedef enum logic [1:0] {
    RIE_IDLE = 2'b00,
    RIE_EXEC = 2'b01,
    RIE_SLOT = 2'b10
  } rie_state_t;

  // decoded form of one instruction word
  typedef struct packed {
    rie_kind_t kind;
    logic restore;
    logic [DATA_W-1:0] literal;
  } rie_dec_t;

  // values held in the shadow copies
  typedef struct packed {
    logic [DATA_W-1:0] accumulator;
    logic [DATA_W-1:0] flags;
    logic [DATA_W-1:0] bank;
  } rie_shadow_t;

  // writes to the live registers, each with its own strobe
  typedef struct packed {
    logic acc_we;
    logic [DATA_W-1:0] acc;
    logic flags_we;
    logic [DATA_W-1:0] flags;
    logic bank_we;
    logic [DATA_W-1:0] bank;
  } rie_regwr_t;

  // stack and pc side of one return
  typedef struct packed {
    logic pop;
    logic pc_load;
    logic [PC_W-1:0] pc;
  } rie_flow_t;

  // interrupt enable set strobes
  typedef struct packed {
    logic set_high;
    logic set_low;
  } rie_ie_t;

endpackage

`default_nettype wire

/* src/rie_phase_gen.sv */
// rie_phase_gen: four-phase instruction clock counter.
// assumes clk_en is high once per core phase.
`default_nettype none

module rie_phase_gen (
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  output logic [1:0] phase
);

  typedef struct packed {
    logic [1:0] phase;
  } rie_ph_state_t;

  rie_ph_state_t st;
  rie_ph_state_t next_st;

  always_comb begin
    next_st = st;
    if (clk_en) begin
      next_st.phase = st.phase + 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st <= '{phase: rie_pkg::PH_Q1};
    end else begin
      st <= next_st;
    end
  end

  assign phase = st.phase;

endmodule

`default_nettype wire

/* src/rie_ret_decode.sv */
// rie_ret_decode: recognises the three return opcodes.
// assumes a stable instruction word; purely combinational.
`default_nettype none

module rie_ret_decode (
  input wire logic [rie_pkg::INSTR_W-1:0] instr,
  output rie_pkg::rie_dec_t dec
);

  always_comb begin
    dec.kind = rie_pkg::RIE_KIND_NONE;
    dec.restore = instr[rie_pkg::SEL_BIT];
    dec.literal = instr[rie_pkg::LIT_LSB +: rie_pkg::DATA_W];
    if ((instr & rie_pkg::RFI_MASK) == rie_pkg::RFI_CODE) begin
      dec.kind = rie_pkg::RIE_KIND_RFI;
    end
    else if ((instr & rie_pkg::RFS_MASK) == rie_pkg::RFS_CODE) begin
      dec.kind = rie_pkg::RIE_KIND_RFS;
    end
    else if ((instr & rie_pkg::RWL_MASK) == rie_pkg::RWL_CODE) begin
      dec.kind = rie_pkg::RIE_KIND_RWL;
    end
  end

endmodule

`default_nettype wire

/* src/rie_return_exec.sv */
// rie_return_exec: executes the three return instructions of the core.
// assumes instr and instr_valid come from the core on the same clock and
// are offered in phase Q1; stack, shadow and enable logic live outside.
`default_nettype none

module rie_return_exec #(
  parameter int PC_W = rie_pkg::PC_W
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic [rie_pkg::INSTR_W-1:0] instr,
  input wire logic instr_valid,
  input wire logic [PC_W-1:0] stack_top,
  input wire rie_pkg::rie_shadow_t shadow,
  input wire logic int_priority_mode,
  input wire logic return_level_high,
  output logic [1:0] phase,
  output logic busy,
  output logic nop_slot,
  output logic stack_pop,
  output logic pc_load,
  output logic [PC_W-1:0] pc_value,
  output rie_pkg::rie_regwr_t reg_write,
  output rie_pkg::rie_ie_t int_enable_set
);

  ////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    rie_pkg::rie_state_t fsm;
    rie_pkg::rie_dec_t op;
    logic level_high;
    logic prio_mode;
    logic stack_pop;
    logic pc_load;
    logic [PC_W-1:0] pc;
    rie_pkg::rie_regwr_t wr;
    rie_pkg::rie_ie_t ie;
  } rie_exec_state_t;

  rie_exec_state_t st;
  rie_exec_state_t next_st;

  rie_pkg::rie_dec_t dec;
  logic q1;
  logic q3;
  logic q4;

  ////////////////////////////////////////////////////////////////////////
  // submodules

  rie_phase_gen u_phase (
    .clk(clk),
    .reset(reset),
    .clk_en(clk_en),
    .phase(phase)
  );

  rie_ret_decode u_decode (
    .instr(instr),
    .dec(dec)
  );

  assign q1 = (phase == rie_pkg::PH_Q1);
  assign q3 = (phase == rie_pkg::PH_Q3);
  assign q4 = (phase == rie_pkg::PH_Q4);

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_st = st;
    if (clk_en) begin
      // strobes last exactly one enabled phase
      next_st.stack_pop = 1'b0;
      next_st.pc_load = 1'b0;
      next_st.wr.acc_we = 1'b0;
      next_st.wr.flags_we = 1'b0;
      next_st.wr.bank_we = 1'b0;
      next_st.ie.set_high = 1'b0;
      next_st.ie.set_low = 1'b0;

      unique case (st.fsm)
        rie_pkg::RIE_IDLE: begin
          if (q1 && instr_valid &&
              dec.kind != rie_pkg::RIE_KIND_NONE) begin
            next_st.fsm = rie_pkg::RIE_EXEC;
            next_st.op = dec;
            // level captured at decode so a late change mid-cycle
            // cannot flip which enable comes back
            next_st.level_high = return_level_high;
            next_st.prio_mode = int_priority_mode;
          end
        end

        rie_pkg::RIE_EXEC: begin
          // strobes raised for the Q4 phase
          if (q3) begin
            // pop and load pc from stack top
            // literal return pops the same way
            // subroutine return pops the same way
            next_st.stack_pop = 1'b1;
            next_st.pc_load = 1'b1;
            // only pc is loaded, latches keep their value
            // no latch strobe exists on this block
            next_st.pc = stack_top;

            unique case (st.op.kind)
              rie_pkg::RIE_KIND_RFI: begin
                // one enable bit: high unless priority mode with level low
                if (!st.prio_mode || st.level_high) begin
                  next_st.ie.set_high = 1'b1;
                end else begin
                  next_st.ie.set_low = 1'b1;
                end
                if (st.op.restore) begin
                  next_st.wr.acc_we = 1'b1;
                  next_st.wr.acc = shadow.accumulator;
                  next_st.wr.flags_we = 1'b1;
                  next_st.wr.flags = shadow.flags;
                  next_st.wr.bank_we = 1'b1;
                  next_st.wr.bank = shadow.bank;
                end
              end

              rie_pkg::RIE_KIND_RFS: begin
                if (st.op.restore) begin
                  next_st.wr.acc_we = 1'b1;
                  next_st.wr.acc = shadow.accumulator;
                  next_st.wr.flags_we = 1'b1;
                  next_st.wr.flags = shadow.flags;
                  next_st.wr.bank_we = 1'b1;
                  next_st.wr.bank = shadow.bank;
                end
              end

              rie_pkg::RIE_KIND_RWL: begin
                next_st.wr.acc_we = 1'b1;
                next_st.wr.acc = st.op.literal;
              end

              default: begin
                // a none code cannot reach exec; drop back safely
                next_st.stack_pop = 1'b0;
                next_st.pc_load = 1'b0;
                next_st.fsm = rie_pkg::RIE_IDLE;
              end
            endcase
          end
          // second cycle opens as a no-op
          if (q4) begin
            next_st.fsm = rie_pkg::RIE_SLOT;
          end
        end

        rie_pkg::RIE_SLOT: begin
          // whole cycle idles, then free for decode
          if (q4) begin
            next_st.fsm = rie_pkg::RIE_IDLE;
          end
        end

        default: begin
          next_st.fsm = rie_pkg::RIE_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clk) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign busy = (st.fsm != rie_pkg::RIE_IDLE);
  assign nop_slot = (st.fsm == rie_pkg::RIE_SLOT);
  assign stack_pop = st.stack_pop;
  assign pc_load = st.pc_load;
  assign pc_value = st.pc;
  assign reg_write = st.wr;
  assign int_enable_set = st.ie;

endmodule

`default_nettype wire

/* tb/rie_return_exec_asserts.sv */
// rie_return_exec_asserts: port timing checks for rie_return_exec.
// assumes clk_en stays high while a return is in flight.
`default_nettype none
module rie_return_exec_asserts #(
  parameter int PC_W = rie_pkg::PC_W
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic [rie_pkg::INSTR_W-1:0] instr,
  input wire logic instr_valid,
  input wire logic [PC_W-1:0] stack_top,
  input wire rie_pkg::rie_shadow_t shadow,
  input wire logic int_priority_mode,
  input wire logic return_level_high,
  input wire logic [1:0] phase,
  input wire logic busy,
  input wire logic nop_slot,
  input wire logic stack_pop,
  input wire logic pc_load,
  input wire logic [PC_W-1:0] pc_value,
  input wire rie_pkg::rie_regwr_t reg_write,
  input wire rie_pkg::rie_ie_t int_enable_set
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  wire logic take = clk_en && phase == rie_pkg::PH_Q1 && instr_valid && !busy;
  wire logic is_lit = (instr & rie_pkg::RWL_MASK) == rie_pkg::RWL_CODE;
  wire logic is_ret = is_lit
    || (instr & rie_pkg::RFI_MASK) == rie_pkg::RFI_CODE
    || (instr & rie_pkg::RFS_MASK) == rie_pkg::RFS_CODE;
  wire logic [7:0] lit = instr[7:0];
  wire logic stepped = stack_pop && clk_en;
  //////////////////////////////////////////////////////////////////////
  sequence s_go;
    take && is_ret ##1 clk_en [*2];
  endsequence
  sequence s_lit;
    take && is_lit ##1 clk_en [*2];
  endsequence
  pop_timing_a: assert property (
    s_go |=> stack_pop && phase == rie_pkg::PH_Q4) else $error("late pop");
  lit_write_a: assert property (
    s_lit |=> reg_write.acc_we && reg_write.acc == $past(lit, 3)
    && !reg_write.flags_we) else $error("bad literal write");
  pop_pair_a: assert property (
    stack_pop == pc_load) else $error("pop without pc load");
  strobe_once_a: assert property (
    stepped |=> !stack_pop) else $error("pop longer than a phase");
  enable_pop_a: assert property (
    (int_enable_set.set_high || int_enable_set.set_low) |->
    stack_pop && !(int_enable_set.set_high && int_enable_set.set_low))
    else $error("bad enable set");
  restore_set_a: assert property (
    reg_write.flags_we |-> reg_write.bank_we && reg_write.acc_we
    && stack_pop) else $error("partial restore");
  busy_span_a: assert property (
    $rose(busy) |-> busy [*7] ##1 !busy) else $error("busy length");
  nop_slot_a: assert property (
    stepped |=> nop_slot [*4] ##1 !nop_slot) else $error("no-op slot");
endmodule
bind rie_return_exec rie_return_exec_asserts #(.PC_W(PC_W))
  rie_return_exec_asserts_inst (.clk(clk), .reset(reset), .clk_en(clk_en),
  .instr(instr), .instr_valid(instr_valid), .stack_top(stack_top),
  .shadow(shadow), .int_priority_mode(int_priority_mode),
  .return_level_high(return_level_high), .phase(phase), .busy(busy),
  .nop_slot(nop_slot), .stack_pop(stack_pop), .pc_load(pc_load),
  .pc_value(pc_value), .reg_write(reg_write),
  .int_enable_set(int_enable_set));
`default_nettype wire

/* tb/tb.sv */
// tb: self-checking bench for rie_return_exec.
// assumes clk_en high except for the closing freeze check; expected strobes go through a queue.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PC_W = rie_pkg::PC_W;
  typedef struct packed {
    logic [PC_W-1:0] pc;
    rie_pkg::rie_regwr_t wr;
    rie_pkg::rie_ie_t ie;
  } rie_exp_t;
  logic clk = 0, reset = 1, clk_en = 1, instr_valid = 0, prio = 0, lvl = 0;
  logic [15:0] instr = '0;
  logic [PC_W-1:0] stack_top = '0, pc_value;
  rie_pkg::rie_shadow_t shadow = '0;
  logic [1:0] phase;
  logic busy, nop_slot, stack_pop, pc_load;
  rie_pkg::rie_regwr_t wr;
  rie_pkg::rie_ie_t ie;
  int n_mismatch = 0;
  int check_count = 0;
  logic [31:0] seed = 32'hd0484ba9;
  rie_exp_t q[$];
  always #12.5 clk = ~clk;
  rie_return_exec rie_return_exec_inst (.clk(clk), .reset(reset),
    .clk_en(clk_en), .instr(instr), .instr_valid(instr_valid),
    .stack_top(stack_top), .shadow(shadow), .int_priority_mode(prio),
    .return_level_high(lvl), .phase(phase), .busy(busy),
    .nop_slot(nop_slot), .stack_pop(stack_pop), .pc_load(pc_load),
    .pc_value(pc_value), .reg_write(wr), .int_enable_set(ie));
  //////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic complete_run;
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////
  task automatic issue(input logic [15:0] w);
    rie_exp_t e;
    int i;
    logic rfi, rfs, rwl;
    i = 0;
    while (!(phase === 2'h0 && busy === 1'b0) && i < 20) begin
      @(negedge clk);
      i++;
    end
    if (i == 20) begin
      n_mismatch++;
      complete_run();
    end
    seed = xs(seed);
    stack_top = seed[PC_W-1:0];
    {prio, lvl} = seed[31:30];
    seed = xs(seed);
    shadow = seed[23:0];
    instr = w;
    instr_valid = 1'b1;
    rfi = (w & rie_pkg::RFI_MASK) == rie_pkg::RFI_CODE;
    rfs = (w & rie_pkg::RFS_MASK) == rie_pkg::RFS_CODE;
    rwl = (w & rie_pkg::RWL_MASK) == rie_pkg::RWL_CODE;
    e = '0;
    e.pc = stack_top;
    e.ie.set_high = rfi && (!prio || lvl);
    e.ie.set_low = rfi && prio && !lvl;
    e.wr.flags_we = (rfi || rfs) && w[0];
    e.wr.bank_we = e.wr.flags_we;
    e.wr.acc_we = rwl || e.wr.flags_we;
    e.wr.acc = rwl ? w[7:0] : shadow.accumulator;
    e.wr.flags = shadow.flags;
    e.wr.bank = shadow.bank;
    if (rfi || rfs || rwl) q.push_back(e);
    @(negedge clk);
    // a second word while busy must be ignored
    instr = 16'h0011;
    @(negedge clk);
    instr_valid = 1'b0;
    if (rfi || rfs || rwl) begin
      repeat (2) @(negedge clk);
      chk("nop_slot", 1, nop_slot);
    end
  endtask
  //////////////////////////////////////////////////////////////////////
  always @(negedge clk) begin
    rie_exp_t e;
    if (!reset && (pc_load | wr.acc_we | wr.flags_we | wr.bank_we
        | ie.set_high | ie.set_low) !== 1'b0) begin
      chk("queue", 1, q.size() > 0);
      e = q.pop_front();
      chk("pc_value", e.pc, pc_value);
      chk("stack_pop", 1, stack_pop);
      chk("enable", e.ie, ie);
      chk("we", {e.wr.acc_we, e.wr.flags_we, e.wr.bank_we},
          {wr.acc_we, wr.flags_we, wr.bank_we});
      if (e.wr.acc_we) chk("acc", e.wr.acc, wr.acc);
      if (e.wr.flags_we) chk("shadow", {e.wr.flags, e.wr.bank},
          {wr.flags, wr.bank});
    end
  end
  initial begin
    logic [15:0] ops[8];
    logic [15:0] w;
    ops = '{16'h0010, 16'h0011, 16'h0012, 16'h0013, 16'h0c00, 16'h0014,
            16'h0d00, 16'h0000};
    repeat (4) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    chk("busy", 0, busy);
    for (int k = 0; k < 48; k++) begin
      seed = xs(seed);
      w = ops[k % 8];
      if (w[15:8] == 8'h0c) w[7:0] = seed[7:0];
      issue(w);
      if (k == 24) begin
        // abort mid-instruction: nothing may follow the reset
        reset = 1'b1;
        q.delete();
        repeat (2) @(negedge clk);
        reset = 1'b0;
        chk("phase", 0, phase);
      end
    end
    repeat (12) @(negedge clk);
    // clock enable low must freeze the phase counter
    w[1:0] = phase;
    clk_en = 1'b0;
    repeat (3) @(negedge clk);
    chk("frozen", w[1:0], phase);
    clk_en = 1'b1;
    chk("left", 0, q.size());
    complete_run();
  end
endmodule
`default_nettype wire
